/* bench/cpu_if_sysreg_enable_ctrl_test.sv */
`timescale 1ns/1ps
`include "csre_defs.svh"
module cpu_if_sysreg_enable_ctrl_test
  import csre_pkg::*;
;
  logic      clk;
  logic      rst_n;
  csre_cfg_s cfg;
  csre_ctx_s ctx;
  csre_req_s req;
  csre_rsp_s rsp;
  csre_rsp_s r;
  logic      ns_g, s_g, irq_bd, fiq_bd, ifen_s, ifen_ns, k_trap;
  int        num_errors;
  int        total_checks;
  csre_level_e lv[3] = '{CSRE_LVL_USER, CSRE_LVL_KERN, CSRE_LVL_HYP};
  csre_cfg_s   fx[3] = '{6'h2C, 6'h23, 6'h30};
  logic [63:0] fxv[3] = '{64'h1, 64'h7, 64'h1};

  csre_ctrl i_csre_ctrl (.clk(clk), .rst_n(rst_n), .cfg(cfg), .ctx(ctx), .req(req), .rsp(rsp),
    .ns_group1_uses_group0(ns_g), .s_group1_uses_group0(s_g), .irq_bypass_disable(irq_bd),
    .fiq_bypass_disable(fiq_bd), .ifen_secure(ifen_s), .ifen_nonsecure(ifen_ns),
    .kernel_other_trap(k_trap));
  csre_core_model i_csre_core_model (.clk(clk), .rsp(rsp), .req(req));

  always #10 clk = ~clk;

  // ****************************************
  // helpers
  // ****************************************
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %0h exp %0h", $time, got, exp);
    end
  endtask

  task automatic mon(input logic wr, input csre_level_e lvl, input logic [63:0] wd);
    i_csre_core_model.access(wr, `CSRE_OP1_MONCTL, `CSRE_OP2_MONCTL, lvl, 1'b0, wd, r);
  endtask

  task automatic kse(input logic wr, input csre_level_e lvl, input logic ns, input logic [63:0] wd);
    i_csre_core_model.access(wr, `CSRE_OP1_KSRE, `CSRE_OP2_KSRE, lvl, ns, wd, r);
  endtask

  task automatic do_reset(input csre_cfg_s c);
    @(posedge clk);
    rst_n <= 1'b0;
    cfg   <= c;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
  endtask

  task automatic end_of_test();
    if (num_errors == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // ****************************************
  // tests
  // ****************************************
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    cfg = '0;
    ctx = '0;
    ctx.mon_ifen = 1'b1;
    ctx.mon_enable = 1'b1;
    num_errors = 0;
    total_checks = 0;
    cfg.has_mon = 1'b1;
    do_reset(cfg);
    kse(1'b0, CSRE_LVL_MON, 1'b0, 64'h0);
    check(r.rdata, 64'h0);
    mon(1'b1, CSRE_LVL_MON, 64'h3);
    check(64'(r.result), 64'(CSRE_RES_OK));
    check(64'({ns_g, s_g}), 64'h3);
    mon(1'b0, CSRE_LVL_MON, 64'h0);
    check(r.rdata, 64'h3);
    mon(1'b1, CSRE_LVL_MON, 64'h2);
    check(64'({ns_g, s_g}), 64'h2);
    // lower levels refused, select bits untouched
    foreach (lv[i]) begin
      mon(1'b1, lv[i], 64'h1);
      check(64'({r.valid, 4'(r.result), ns_g, s_g}), 64'({1'b1, 4'(CSRE_RES_UNDEF), 2'h2}));
    end
    i_csre_core_model.access(1'b0, `CSRE_OP1_MONCTL, 3'h7, CSRE_LVL_MON, 1'b0, 64'h0, r);
    check(64'(r.valid), 64'h0);
    ctx.mon_ifen <= 1'b0;
    mon(1'b0, CSRE_LVL_MON, 64'h0);
    check(64'({4'(r.result), 2'(r.trap_level), r.syndrome}), 64'({4'(CSRE_RES_TRAP), 2'h3, 6'h18}));
    kse(1'b1, CSRE_LVL_MON, 1'b0, 64'h1);
    check(64'({ifen_s, k_trap, r.rdata[0]}), 64'h2);
    ctx.mon_ifen <= 1'b1;
    kse(1'b1, CSRE_LVL_MON, 1'b0, 64'h1);
    check(64'({ifen_s, k_trap}), 64'h2);
    kse(1'b1, CSRE_LVL_KERN, 1'b1, 64'h0);
    check(64'({ifen_ns, k_trap}), 64'h1);
    ctx.mon_irq_bd <= 1'b1;
    kse(1'b1, CSRE_LVL_MON, 1'b0, 64'h1);
    check(64'({irq_bd, fiq_bd}), 64'h2);
    kse(1'b0, CSRE_LVL_MON, 1'b0, 64'h0);
    check(r.rdata, 64'h5);
    // monitor alias back to zero so only the straps and the model's sticky secure enable force ones
    ctx.mon_irq_bd <= 1'b0;
    // fixed-one straps, then has_mon with has_hyp only (6'h30), each after a fresh reset; zero writes go out with bit 0 forced to one by the model
    foreach (fx[i]) begin
      do_reset(fx[i]);
      kse(1'b1, CSRE_LVL_MON, 1'b0, 64'h0);
      kse(1'b0, CSRE_LVL_MON, 1'b0, 64'h0);
      check(r.rdata, fxv[i]);
    end
    end_of_test();
  end

  // ****************************************
  // watchdog
  // ****************************************
  initial begin
    #100us;
    num_errors++;
    end_of_test();
  end
endmodule

/* bench/csre_core_model.sv */
`timescale 1ns/1ps
`include "csre_defs.svh"
module csre_core_model
  import csre_pkg::*;
(
  input  wire  logic      clk,
  input  wire  csre_rsp_s rsp,
  output csre_req_s       req
);
  // ****************************************
  // core issuing register instructions
  // ****************************************
  logic sec_set;

  initial begin
    req     = '0;
    sec_set = 1'b0;
  end

  // one-cycle request, fields held after it so combinational outputs stay defined
  task automatic access(input logic wr, input logic [2:0] op1, input logic [2:0] op2,
                        input csre_level_e lvl, input logic ns, input logic [63:0] wd,
                        output csre_rsp_s r);
    logic [63:0] d;
    d = wd;
    // software keeps the secure enable once set
    if (wr && !ns && op2 == `CSRE_OP2_KSRE) begin
      if (sec_set) d[0] = 1'b1;
      sec_set = sec_set | d[0];
    end
    @(posedge clk);
    req <= {1'b1, wr, `CSRE_OP0, op1, `CSRE_CRN, `CSRE_CRM, op2, lvl, ns, d};
    @(posedge clk);
    req.valid <= 1'b0;
    #1 r = rsp;
  endtask
endmodule

/* hw/csre_ctrl.sv */
// Operation
// - ns select 0: separate group1 binary point
// - ns select 1: group0 point governs both
// - secure select same for secure group1
// - select bits unspecified after warm reset
// - lower levels: monitor control access undefined
// - monitor level traps 0x18 unless enabled
// - decode monitor control register encoding
// - irq bypass disable, fixed one if absent
// - fiq bypass disable, fixed one if absent
// - bypass bits alias monitor or hypervisor copies
// - interface enable zero: kernel accesses trap
// - sysreg-only implementation: enable reads one
// - secure enable zero while monitor bit zero
// - nonsecure enable zero while higher bits zero
// - realm extension: enable reads one
// - fixed-one copies need fixed higher bits
// - kernel enable bits reset to zero
`timescale 1ns/1ps
`include "csre_defs.svh"
module csre_ctrl
  import csre_pkg::*;
(
  input  wire  logic      clk,
  input  wire  logic      rst_n,
  input  wire  csre_cfg_s cfg,
  input  wire  csre_ctx_s ctx,
  input  wire  csre_req_s req,
  output csre_rsp_s       rsp,
  output logic            ns_group1_uses_group0,
  output logic            s_group1_uses_group0,
  output logic            irq_bypass_disable,
  output logic            fiq_bypass_disable,
  output logic            ifen_secure,
  output logic            ifen_nonsecure,
  output logic            kernel_other_trap
);

  // ****************************************
  // state
  // ****************************************
  logic      cp_ns;
  logic      cp_s;
  logic      irq_bd;
  logic      fiq_bd;
  logic      en_s;
  logic      en_ns;
  csre_rsp_s rsp_q;
  logic      next_cp_ns;
  logic      next_cp_s;
  logic      next_irq_bd;
  logic      next_fiq_bd;
  logic      next_en_s;
  logic      next_en_ns;
  csre_rsp_s next_rsp;
  logic      hit_monctl;
  logic      hit_ksre;
  logic      ifen_fixed;
  logic      s_gate;
  logic      ns_gate;
  logic      bd_rw;
  logic      eff_irq;
  logic      eff_fiq;
  logic      eff_en;

  csre_decode i_csre_decode (
    .req        (req),
    .hit_monctl (hit_monctl),
    .hit_ksre   (hit_ksre)
  );

  // ****************************************
  // effective field values
  // ****************************************
  always_comb begin
    // fixed one only legal when higher copies are fixed too; integrator's job
    ifen_fixed = cfg.sysreg_only || cfg.realm_ext;
    s_gate     = cfg.has_mon && !ctx.mon_ifen;
    ns_gate    = (cfg.has_hyp && !ctx.hyp_ifen) || s_gate;
    bd_rw      = cfg.has_mon && ctx.dist_sec_dis && !cfg.has_hyp;
    if (cfg.no_irq_bypass) begin
      eff_irq = 1'b1;
    end else if (cfg.has_hyp && (!cfg.has_mon || ctx.dist_sec_dis)) begin
      eff_irq = ctx.hyp_irq_bd;
    end else if (cfg.has_mon) begin
      eff_irq = ctx.mon_irq_bd;
    end else begin
      eff_irq = irq_bd;
    end
    if (cfg.no_fiq_bypass) begin
      eff_fiq = 1'b1;
    end else if (cfg.has_hyp && (!cfg.has_mon || ctx.dist_sec_dis)) begin
      eff_fiq = ctx.hyp_fiq_bd;
    end else if (cfg.has_mon) begin
      eff_fiq = ctx.mon_fiq_bd;
    end else begin
      eff_fiq = fiq_bd;
    end
    ifen_secure    = ifen_fixed ? 1'b1 : (s_gate ? 1'b0 : en_s);
    ifen_nonsecure = ifen_fixed ? 1'b1 : (ns_gate ? 1'b0 : en_ns);
    eff_en         = req.nonsecure ? ifen_nonsecure : ifen_secure;
    kernel_other_trap = !eff_en;
    ns_group1_uses_group0 = cp_ns;
    s_group1_uses_group0  = cp_s;
    irq_bypass_disable    = eff_irq;
    fiq_bypass_disable    = eff_fiq;
  end

  // ****************************************
  // access handling
  // ****************************************
  always_comb begin
    next_cp_ns  = cp_ns;
    next_cp_s   = cp_s;
    next_irq_bd = irq_bd;
    next_fiq_bd = fiq_bd;
    next_en_s   = en_s;
    next_en_ns  = en_ns;
    next_rsp    = '0;
    next_rsp.result = CSRE_RES_OK;
    if (hit_monctl) begin
      next_rsp.valid = 1'b1;
      case (req.level)
        CSRE_LVL_MON: begin
          if (!ctx.mon_ifen) begin
            next_rsp.result     = CSRE_RES_TRAP;
            next_rsp.trap_level = 2'h3;
            next_rsp.syndrome   = `CSRE_SYNDROME;
          end else if (req.write) begin
            next_cp_ns = req.wdata[`CSRE_CP_NS_BIT];
            next_cp_s  = req.wdata[`CSRE_CP_S_BIT];
          end else begin
            next_rsp.rdata[`CSRE_CP_NS_BIT] = cp_ns;
            next_rsp.rdata[`CSRE_CP_S_BIT]  = cp_s;
          end
        end
        default: begin
          next_rsp.result = CSRE_RES_UNDEF;
        end
      endcase
    end else if (hit_ksre) begin
      next_rsp.valid = 1'b1;
      case (req.level)
        CSRE_LVL_KERN, CSRE_LVL_HYP, CSRE_LVL_MON: begin
          if (req.level == CSRE_LVL_KERN && req.nonsecure && cfg.has_hyp && !ctx.hyp_enable) begin
            next_rsp.result     = CSRE_RES_TRAP;
            next_rsp.trap_level = 2'h2;
            next_rsp.syndrome   = `CSRE_SYNDROME;
          end else if (req.level != CSRE_LVL_MON && cfg.has_mon && !ctx.mon_enable) begin
            next_rsp.result     = CSRE_RES_TRAP;
            next_rsp.trap_level = 2'h3;
            next_rsp.syndrome   = `CSRE_SYNDROME;
          end else if (req.write) begin
            if (!cfg.no_irq_bypass && (bd_rw || !cfg.has_mon && !cfg.has_hyp)) begin
              next_irq_bd = req.wdata[`CSRE_IRQ_BD_BIT];
            end
            if (!cfg.no_fiq_bypass && (bd_rw || !cfg.has_mon && !cfg.has_hyp)) begin
              next_fiq_bd = req.wdata[`CSRE_FIQ_BD_BIT];
            end
            // secure 1->0 clear is left to software to avoid
            if (!ifen_fixed && !req.nonsecure && !s_gate) begin
              next_en_s = req.wdata[`CSRE_IFEN_BIT];
            end
            if (!ifen_fixed && req.nonsecure && !ns_gate) begin
              next_en_ns = req.wdata[`CSRE_IFEN_BIT];
            end
          end else begin
            next_rsp.rdata[`CSRE_IRQ_BD_BIT] = eff_irq;
            next_rsp.rdata[`CSRE_FIQ_BD_BIT] = eff_fiq;
            next_rsp.rdata[`CSRE_IFEN_BIT]   = eff_en;
          end
        end
        default: begin
          next_rsp.result = CSRE_RES_UNDEF;
        end
      endcase
    end
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cp_ns  <= `CSRE_CP_RESET;
      cp_s   <= `CSRE_CP_RESET;
      irq_bd <= `CSRE_KSRE_RESET;
      fiq_bd <= `CSRE_KSRE_RESET;
      en_s   <= `CSRE_KSRE_RESET;
      en_ns  <= `CSRE_KSRE_RESET;
      rsp_q  <= '0;
    end else begin
      cp_ns  <= next_cp_ns;
      cp_s   <= next_cp_s;
      irq_bd <= next_irq_bd;
      fiq_bd <= next_fiq_bd;
      en_s   <= next_en_s;
      en_ns  <= next_en_ns;
      rsp_q  <= next_rsp;
    end
  end

  assign rsp = rsp_q;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  lower_undef_a: assert property (hit_monctl && req.level != CSRE_LVL_MON |=> rsp.result == CSRE_RES_UNDEF)
    else $error("monitor control access below monitor not undefined");
  mon_trap_a: assert property (hit_monctl && req.level == CSRE_LVL_MON && !ctx.mon_ifen
      |=> rsp.result == CSRE_RES_TRAP && rsp.syndrome == 6'h18)
    else $error("monitor control trap missing");
  cp_write_a: assert property (hit_monctl && req.level == CSRE_LVL_MON && ctx.mon_ifen && req.write
      |=> ns_group1_uses_group0 == $past(req.wdata[1]) && s_group1_uses_group0 == $past(req.wdata[0]))
    else $error("select bits not written");
  ns_hold_a: assert property (!hit_monctl |=> $stable(ns_group1_uses_group0))
    else $error("ns select changed without write");
  s_hold_a: assert property (!hit_monctl |=> $stable(s_group1_uses_group0))
    else $error("secure select changed without write");
  decode_a: assert property (hit_monctl |-> req.op1 == 3'h6 && req.op2 == 3'h4 && req.crn == 4'hC)
    else $error("bad monitor control decode");
  irq_fixed_a: assert property (cfg.no_irq_bypass |-> irq_bypass_disable)
    else $error("irq bypass not fixed one");
  fiq_fixed_a: assert property (cfg.no_fiq_bypass |-> fiq_bypass_disable)
    else $error("fiq bypass not fixed one");
  ifen_fix_a: assert property (cfg.sysreg_only || cfg.realm_ext |-> ifen_secure && ifen_nonsecure)
    else $error("enable not fixed one");
  s_gate_a: assert property (cfg.has_mon && !ctx.mon_ifen && !cfg.sysreg_only && !cfg.realm_ext
      |-> !ifen_secure && !ifen_nonsecure)
    else $error("gated enable reads one");
  ns_gate_a: assert property (cfg.has_hyp && !ctx.hyp_ifen && !cfg.sysreg_only && !cfg.realm_ext
      |-> !ifen_nonsecure)
    else $error("ns enable not gated");
  trap_out_a: assert property (kernel_other_trap == !(req.nonsecure ? ifen_nonsecure : ifen_secure))
    else $error("kernel trap mismatch");

  mon_write_c: cover property (hit_monctl && req.level == CSRE_LVL_MON && req.write && ctx.mon_ifen);
  mon_trap_c:  cover property (hit_monctl && req.level == CSRE_LVL_MON && !ctx.mon_ifen);
  ksre_read_c: cover property (hit_ksre && !req.write && req.level == CSRE_LVL_KERN);

endmodule

/* hw/csre_decode.sv */
`timescale 1ns/1ps
`include "csre_defs.svh"
module csre_decode
  import csre_pkg::*;
(
  input  wire csre_req_s req,
  output logic           hit_monctl,
  output logic           hit_ksre
);

  // ****************************************
  // encoding match
  // ****************************************
  function automatic logic enc_match(input csre_req_s r, input logic [2:0] op1, input logic [2:0] op2);
    enc_match = (r.op0 == `CSRE_OP0) && (r.op1 == op1) && (r.crn == `CSRE_CRN)
             && (r.crm == `CSRE_CRM) && (r.op2 == op2);
  endfunction

  always_comb begin
    hit_monctl = req.valid && enc_match(req, `CSRE_OP1_MONCTL, `CSRE_OP2_MONCTL);
    hit_ksre   = req.valid && enc_match(req, `CSRE_OP1_KSRE, `CSRE_OP2_KSRE);
  end

endmodule

/* inc/csre_defs.svh */
`ifndef CSRE_DEFS_SVH
`define CSRE_DEFS_SVH

// ****************************************
// register encodings (op0 op1 crn crm op2)
// ****************************************
`define CSRE_OP0          2'h3
`define CSRE_OP1_MONCTL   3'h6
`define CSRE_CRN          4'hC
`define CSRE_CRM          4'hC
`define CSRE_OP2_MONCTL   3'h4
`define CSRE_OP1_KSRE     3'h0
`define CSRE_OP2_KSRE     3'h5

// ****************************************
// field positions
// ****************************************
`define CSRE_CP_NS_BIT    1
`define CSRE_CP_S_BIT     0
`define CSRE_IRQ_BD_BIT   2
`define CSRE_FIQ_BD_BIT   1
`define CSRE_IFEN_BIT     0

// ****************************************
// reset values and syndrome
// ****************************************
`define CSRE_KSRE_RESET   1'h0
`define CSRE_CP_RESET     1'h0
`define CSRE_SYNDROME     6'h18

`endif

/* inc/csre_pkg.sv */
package csre_pkg;

  typedef enum logic [3:0] {
    CSRE_LVL_USER  = 4'h1,
    CSRE_LVL_KERN  = 4'h2,
    CSRE_LVL_HYP   = 4'h4,
    CSRE_LVL_MON   = 4'h8
  } csre_level_e;

  typedef enum logic [2:0] {
    CSRE_RES_OK    = 3'h1,
    CSRE_RES_UNDEF = 3'h2,
    CSRE_RES_TRAP  = 3'h4
  } csre_result_e;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [1:0]  op0;
    logic [2:0]  op1;
    logic [3:0]  crn;
    logic [3:0]  crm;
    logic [2:0]  op2;
    csre_level_e level;
    logic        nonsecure;
    logic [63:0] wdata;
  } csre_req_s;

  typedef struct packed {
    logic         valid;
    csre_result_e result;
    logic [1:0]   trap_level;
    logic [5:0]   syndrome;
    logic [63:0]  rdata;
  } csre_rsp_s;

  typedef struct packed {
    logic has_mon;
    logic has_hyp;
    logic sysreg_only;
    logic realm_ext;
    logic no_irq_bypass;
    logic no_fiq_bypass;
  } csre_cfg_s;

  typedef struct packed {
    logic mon_ifen;
    logic hyp_ifen;
    logic mon_enable;
    logic hyp_enable;
    logic mon_irq_bd;
    logic mon_fiq_bd;
    logic hyp_irq_bd;
    logic hyp_fiq_bd;
    logic dist_sec_dis;
  } csre_ctx_s;

endpackage
